/* File: sim/crs_link_asserts.sv */
// Checker for the control link between the reset sequencer and its host.
// Assumes one clock; the supply levels are driven by the bench.
`timescale 1ns/1ps
module crs_link_asserts
  import crs_pkg::*;
(
  input wire logic                  sys_clk,
  input wire logic                  reset,
  input wire logic                  analog_supply_rail,
  input wire logic                  core_supply_rail,
  input wire logic                  wr_stb,
  input wire logic                  rd_stb,
  input wire logic [CRS_ADDR_W-1:0] addr,
  input wire logic [CRS_DATA_W-1:0] wdata,
  input wire logic [CRS_DATA_W-1:0] rdata,
  input wire logic                  rvalid,
  input wire logic                  sw_reset_active
);
  wire logic good = analog_supply_rail && core_supply_rail;

  // One clock domain; the host reset masks the start-up cycles.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Reads are answered one cycle later, and only reads are answered.
  read_answer_a: assert property (rd_stb && !wr_stb |=> rvalid) else $error("read not answered");
  answer_cause_a: assert property (rvalid |-> $past(rd_stb)) else $error("answer without read");
  // A low rail holds reset, so reads then see defaults only.
  low_reads_zero_a: assert property (!good && $past(!good) && rd_stb && !wr_stb |=> rdata == '0)
    else $error("read in reset not default");
  // Answer data holds between reads while the rails are steady.
  rdata_hold_a: assert property (good && $past(good) && $past(good, 2) && $past(good, 3) && !rvalid
    && !$past(wr_stb) |-> $stable(rdata)) else $error("read data moved");
  // A register-zero write made while the device is known to run enters software reset.
  // A non-zero answer proves the run state, and steady rails keep it until the write.
  swrst_clear_a: assert property (rvalid && rdata != '0 && good && $past(good) ##1 good ##1 wr_stb
    && addr == CRS_SWRST_OFFSET |=> sw_reset_active) else $error("software reset not entered");
  unmapped_zero_a: assert property (rd_stb && !wr_stb && (addr == CRS_SWRST_OFFSET || addr >= CRS_NUM_REGS)
    |=> rdata == '0) else $error("unmapped read not zero");
  // The host stays quiet as it leaves reset and issues one strobe a cycle.
  quiet_reset_a: assert property ($fell(reset) |-> !wr_stb && !rd_stb) else $error("strobe after host reset");
  one_strobe_a: assert property (!(wr_stb && rd_stb)) else $error("two strobes in one cycle");
endmodule : crs_link_asserts

/* File: sim/tb.sv */
// Bench joining the reset sequencer and its host over the control link.
// Assumes package and interface compile first; the bench drives the supplies.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED at %0t: %s", $time, msg); end end
module tb;
  import crs_pkg::*;
  logic       sys_clk;
  logic       reset;
  logic       analog_supply_rail;
  logic       core_supply_rail;
  logic [8:0] init_word;
  logic       sw_reset_active;
  logic       dev_ready;
  logic       dropout_seen;
  logic [8:0] ctrl_word;
  logic       saw_swrst;
  int         failures;
  int         n_compared;
  int         n;
  int         k;

  crs_ctrl_if ctrl ();
  crs_device i_crs_device (.sys_clk(sys_clk), .analog_supply_rail(analog_supply_rail),
    .core_supply_rail(core_supply_rail), .ctrl(ctrl), .sw_reset_active(sw_reset_active), .ctrl_word(ctrl_word));
  crs_host i_crs_host (.sys_clk(sys_clk), .reset(reset), .init_word(init_word), .ctrl(ctrl),
    .dev_ready(dev_ready), .dropout_seen(dropout_seen));
  crs_link_asserts i_crs_link_asserts (.sys_clk(sys_clk), .reset(reset), .analog_supply_rail(analog_supply_rail),
    .core_supply_rail(core_supply_rail), .wr_stb(ctrl.wr_stb), .rd_stb(ctrl.rd_stb), .addr(ctrl.addr),
    .wdata(ctrl.wdata), .rdata(ctrl.rdata), .rvalid(ctrl.rvalid), .sw_reset_active(sw_reset_active));

  // Free-running 100 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Remembers that the device entered software reset at some point.
  always @(posedge sys_clk) begin
    if (reset) saw_swrst <= 1'b0;
    else if (sw_reset_active === 1'b1) saw_swrst <= 1'b1;
  end

  // A zero word would look like a default, so the draw skips it.
  function automatic logic [8:0] rand_word();
    return 9'($urandom % 511 + 1);
  endfunction : rand_word

  // Ready must follow the full extension but come inside its maximum plus setup.
  function automatic logic ext_ok(input int cycles);
    return cycles >= CRS_EXT_CYCLES && cycles <= CRS_EXT_MAX_US * CRS_CLK_MHZ + 200;
  endfunction : ext_ok

  task automatic set_rails(input logic a, input logic c);
    @(posedge sys_clk);
    analog_supply_rail <= a;
    core_supply_rail   <= c;
  endtask : set_rails

  // Bounded wait for either a ready host with the new word or a dropout report.
  task automatic wait_for(input logic ready);
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while ((ready ? !(dev_ready === 1'b1 && ctrl_word === init_word) : dropout_seen !== 1'b1) && n < 30000);
  endtask : wait_for

  task automatic test_done();
    $display("compared %0d, failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  // Watchdog: the span covers power-on and three dropout rounds with margin.
  initial begin
    repeat (90000) @(posedge sys_clk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end

  // Main sequence: power-on, then dropouts in run and during the extension.
  initial begin
    reset              = 1'b1;
    analog_supply_rail = 1'b0;
    core_supply_rail   = 1'b0;
    init_word          = 9'h000;
    failures           = 0;
    n_compared         = 0;
    void'($urandom(94062));
    repeat (10) @(posedge sys_clk);
    reset     <= 1'b0;
    init_word <= rand_word();
    set_rails(1'b1, 1'b1);
    n = 0;
    wait_for(1'b1);
    `CHK(ext_ok(n), 1'b1, "power-on extension length")
    `CHK(ctrl_word, init_word, "operating word missing")
    `CHK(sw_reset_active, 1'b0, "software reset not ended")
    `CHK(saw_swrst, 1'b1, "no software reset seen")
    $display("test power_on done");
    for (int r = 0; r < 3; r++) begin
      k = $urandom % 2;
      set_rails(k != 0, k == 0);
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK(ctrl_word, 9'h000, "register kept in reset")
      // The rail stays low until the poll notices, so the host then probes through the whole extension.
      n = 0;
      wait_for(1'b0);
      `CHK(n < 30000, 1'b1, "dropout not reported")
      set_rails(1'b1, 1'b1);
      init_word <= rand_word();
      if (r == 1) begin
        repeat (2500) @(posedge sys_clk);
        set_rails(k == 0, k != 0);
        repeat (3) @(posedge sys_clk);
        set_rails(1'b1, 1'b1);
      end
      n = 0;
      wait_for(1'b1);
      `CHK(ext_ok(n), 1'b1, "fresh extension skipped")
      `CHK(ctrl_word, init_word, "word after recovery")
      $display("test dropout round %0d done", r);
    end
    test_done();
  end
endmodule : tb

/* File: verilog/crs_ctrl_if.sv */
// Control link between the codec reset sequencer and its host controller.
// Assumes both ends share sys_clk; accesses are one-cycle strobes.
`timescale 1ns/1ps
interface crs_ctrl_if;
  import crs_pkg::*;
  logic                  wr_stb;
  logic                  rd_stb;
  logic [CRS_ADDR_W-1:0] addr;
  logic [CRS_DATA_W-1:0] wdata;
  logic [CRS_DATA_W-1:0] rdata;
  logic                  rvalid;

  modport device (input wr_stb, input rd_stb, input addr, input wdata, output rdata, output rvalid);
  modport host   (output wr_stb, output rd_stb, output addr, output wdata, input rdata, input rvalid);
endinterface : crs_ctrl_if

/* File: verilog/crs_device.sv */
// Codec reset sequencer: supply-driven internal reset, extension timer, software reset and register file.
// Assumes supply indications are synchronous to sys_clk and the host speaks over crs_ctrl_if.
//
// Notes on behaviour
// RULE_01 - Hold reset while either supply is low.
// RULE_02 - Reset forces all registers to defaults.
// RULE_03 - Ignore control accesses while reset held.
// RULE_04 - Extend reset about 50 us, under 100.
// RULE_05 - Supply drop re-enters reset immediately.
// RULE_06 - Recovery restarts a fresh extension interval.
// RULE_07 - No external reset input exists.
// RULE_08 - Reset state has no readable status.
// RULE_09 - Host probes reset end by readback.
// RULE_10 - Host should issue software reset afterwards.
// RULE_11 - Host polls test bit for dropouts.
// RULE_12 - Write to register zero restores defaults.
// RULE_13 - Next nonzero-address write ends software reset.
// RULE_14 - Host rewrites needed registers after reset.
// RULE_15 - Extension counter clears on invalid supply.
`timescale 1ns/1ps
module crs_device
  import crs_pkg::*;
(
  input  wire logic        sys_clk,              // Free-running clock; no reset pin by design. [RULE_07]
  input  wire logic        analog_supply_rail,   // High when the analog supply is above threshold.
  input  wire logic        core_supply_rail,     // High when the core supply is above threshold.
  crs_ctrl_if.device       ctrl,
  output logic             sw_reset_active,      // High from a register-zero write until the next other write or until the device re-enters reset.
  output logic [8:0]       ctrl_word             // Contents of register one, steering codec logic.
);
  crs_state_e             state_reg, state_next;
  logic [CRS_CNT_W-1:0]   cnt_reg, cnt_next;
  logic [CRS_DATA_W-1:0]  regs_reg  [CRS_NUM_REGS];
  logic [CRS_DATA_W-1:0]  regs_next [CRS_NUM_REGS];
  logic                   swr_reg, swr_next;
  logic [CRS_DATA_W-1:0]  rdata_reg, rdata_next;
  logic                   rvalid_reg, rvalid_next;
  logic                   supplies_ok;
  logic                   in_reset;
  logic                   wr_ok;

  assign supplies_ok = analog_supply_rail & core_supply_rail;  // [RULE_01]
  assign in_reset    = (state_reg != CRS_ST_RUN);

  // Power-on sequencer. Supply loss wins over every state so reset re-enters at once.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (!supplies_ok) begin
      state_next = CRS_ST_HOLD;          // [RULE_01] [RULE_05]
      cnt_next   = '0;                   // [RULE_15]
    end else begin
      unique case (state_reg)
        CRS_ST_HOLD: begin
          state_next = CRS_ST_EXTEND;    // Fresh interval after every recovery. [RULE_06]
          cnt_next   = '0;
        end
        CRS_ST_EXTEND: begin
          if (cnt_reg == CRS_CNT_W'(CRS_EXT_CYCLES - 1)) begin
            state_next = CRS_ST_RUN;     // [RULE_04] [RULE_15]
          end else begin
            cnt_next = cnt_reg + 1'b1;
          end
        end
        CRS_ST_RUN: begin
          state_next = CRS_ST_RUN;
        end
        default: begin
          state_next = CRS_ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    state_reg <= state_next;
    cnt_reg   <= cnt_next;
  end

  // Register file. Reset status is deliberately not readable; hosts infer it from contents. [RULE_08]
  assign wr_ok = ctrl.wr_stb & ~in_reset;  // [RULE_03]

  always_comb begin
    for (int i = 0; i < CRS_NUM_REGS; i++) begin
      regs_next[i] = regs_reg[i];
    end
    swr_next    = swr_reg;
    rdata_next  = rdata_reg;
    rvalid_next = 1'b0;
    if (in_reset) begin
      for (int i = 0; i < CRS_NUM_REGS; i++) begin
        regs_next[i] = CRS_REG_RESET_VAL;  // [RULE_02]
      end
      swr_next    = 1'b0;
      rdata_next  = '0;
      rvalid_next = ctrl.rd_stb;           // Answered with zeros so a probing host keeps moving. [RULE_03]
    end else if (wr_ok && ctrl.addr == CRS_SWRST_OFFSET) begin
      for (int i = 0; i < CRS_NUM_REGS; i++) begin
        regs_next[i] = CRS_REG_RESET_VAL;  // Any data value triggers it. [RULE_12]
      end
      swr_next = 1'b1;
    end else if (wr_ok) begin
      swr_next = 1'b0;                     // [RULE_13]
      if (ctrl.addr < CRS_ADDR_W'(CRS_NUM_REGS)) begin
        regs_next[ctrl.addr[2:0]] = ctrl.wdata;
      end
    end else if (ctrl.rd_stb) begin
      rvalid_next = 1'b1;
      // Unmapped and write-only addresses read as zero.
      if (ctrl.addr < CRS_ADDR_W'(CRS_NUM_REGS) && ctrl.addr != CRS_SWRST_OFFSET) begin
        rdata_next = regs_reg[ctrl.addr[2:0]];
      end else begin
        rdata_next = '0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < CRS_NUM_REGS; i++) begin
      regs_reg[i] <= regs_next[i];
    end
    swr_reg    <= swr_next;
    rdata_reg  <= rdata_next;
    rvalid_reg <= rvalid_next;
  end

  // Reads during reset still answer, with zeros, so a polling host never hangs.
  assign ctrl.rdata      = rdata_reg;
  assign ctrl.rvalid     = rvalid_reg;
  assign sw_reset_active = swr_reg;
  assign ctrl_word       = regs_reg[1];
endmodule : crs_device

/* File: verilog/crs_host.sv */
// Host controller end: probes for reset end, issues software reset, initialises and polls a test bit.
// Assumes the device end answers reads one cycle after the read strobe.
`timescale 1ns/1ps
module crs_host
  import crs_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,         // Synchronous, active high.
  input  wire logic [8:0]  init_word,     // Operating value for register one.
  crs_ctrl_if.host         ctrl,
  output logic             dev_ready,     // High once the device is initialised.
  output logic             dropout_seen   // One-cycle pulse when a dropout is detected.
);
  crs_host_e             st_reg, st_next;
  logic [CRS_CNT_W-1:0]  tmr_reg, tmr_next;
  logic                  wr_reg, wr_next;
  logic                  rd_reg, rd_next;
  logic [6:0]            addr_reg, addr_next;
  logic [8:0]            wd_reg, wd_next;
  logic                  rdy_reg, rdy_next;
  logic                  drop_reg, drop_next;
  logic                  pend_reg, pend_next;

  // Sequence; a pending flag waits for the one-cycle read answer.
  always_comb begin
    st_next   = st_reg;
    tmr_next  = tmr_reg;
    wr_next   = 1'b0;
    rd_next   = 1'b0;
    addr_next = addr_reg;
    wd_next   = wd_reg;
    rdy_next  = rdy_reg;
    drop_next = 1'b0;
    pend_next = pend_reg;
    unique case (st_reg)
      CRS_H_IDLE, CRS_H_PROBE_WR: begin
        // Write a non-default test value away from register zero. [RULE_09]
        wr_next   = 1'b1;
        addr_next = CRS_TEST_OFFSET;
        wd_next   = CRS_TEST_VALUE;
        st_next   = CRS_H_PROBE_RD;
        pend_next = 1'b0;
      end
      CRS_H_PROBE_RD: begin
        if (!pend_reg && !wr_reg) begin
          rd_next   = 1'b1;
          pend_next = 1'b1;
        end else if (ctrl.rvalid) begin
          pend_next = 1'b0;
          st_next   = (ctrl.rdata == CRS_TEST_VALUE) ? CRS_H_SWRST : CRS_H_PROBE_WR;  // [RULE_09]
        end
      end
      CRS_H_SWRST: begin
        wr_next   = 1'b1;                   // [RULE_10]
        addr_next = CRS_SWRST_OFFSET;
        wd_next   = '0;
        st_next   = CRS_H_INIT;
      end
      CRS_H_INIT: begin
        // Rewrite the operating value, then arm the dropout test bit. [RULE_14] [RULE_11]
        wr_next = 1'b1;
        if (addr_reg == CRS_SWRST_OFFSET) begin
          addr_next = 7'h01;
          wd_next   = init_word;
        end else begin
          addr_next = CRS_TEST_OFFSET;
          wd_next   = CRS_TEST_VALUE;
          st_next   = CRS_H_READY;
        end
      end
      CRS_H_READY: begin
        rdy_next = 1'b1;
        tmr_next = '0;
        st_next  = CRS_H_WAIT;
      end
      CRS_H_WAIT: begin
        if (tmr_reg == CRS_CNT_W'(CRS_POLL_CYCLES - 1)) begin
          rd_next   = 1'b1;
          addr_next = CRS_TEST_OFFSET;
          pend_next = 1'b1;
          st_next   = CRS_H_CHECK;
        end else begin
          tmr_next = tmr_reg + 1'b1;
        end
      end
      CRS_H_CHECK: begin
        if (ctrl.rvalid) begin
          pend_next = 1'b0;
          if (ctrl.rdata != CRS_TEST_VALUE) begin
            drop_next = 1'b1;               // Default readback means a reset happened. [RULE_11]
            rdy_next  = 1'b0;
            st_next   = CRS_H_PROBE_WR;
          end else begin
            st_next = CRS_H_READY;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_reg   <= CRS_H_IDLE;
      tmr_reg  <= '0;
      wr_reg   <= 1'b0;
      rd_reg   <= 1'b0;
      addr_reg <= 7'h00;
      wd_reg   <= 9'h000;
      rdy_reg  <= 1'b0;
      drop_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      tmr_reg  <= tmr_next;
      wr_reg   <= wr_next;
      rd_reg   <= rd_next;
      addr_reg <= addr_next;
      wd_reg   <= wd_next;
      rdy_reg  <= rdy_next;
      drop_reg <= drop_next;
      pend_reg <= pend_next;
    end
  end

  assign ctrl.wr_stb  = wr_reg;
  assign ctrl.rd_stb  = rd_reg;
  assign ctrl.addr    = addr_reg;
  assign ctrl.wdata   = wd_reg;
  assign dev_ready    = rdy_reg;
  assign dropout_seen = drop_reg;
endmodule : crs_host

/* File: verilog/crs_pkg.sv */
// Shared constants and types for the codec reset sequencer and its host end.
// Assumes a single 100 MHz system clock shared by both ends.
package crs_pkg;
  localparam int          CRS_CLK_MHZ       = 100;
  localparam int          CRS_EXT_TYP_US    = 50;
  localparam int          CRS_EXT_MAX_US    = 100;
  localparam int          CRS_EXT_CYCLES    = CRS_EXT_TYP_US * CRS_CLK_MHZ;
  localparam int          CRS_POLL_US       = 100;
  localparam int          CRS_POLL_CYCLES   = CRS_POLL_US * CRS_CLK_MHZ;
  localparam int          CRS_ADDR_W        = 7;
  localparam int          CRS_DATA_W        = 9;
  localparam int          CRS_NUM_REGS      = 8;
  localparam logic [6:0]  CRS_SWRST_OFFSET  = 7'h00;
  localparam logic [6:0]  CRS_TEST_OFFSET   = 7'h07;
  localparam logic [8:0]  CRS_REG_RESET_VAL = 9'h000;
  localparam logic [8:0]  CRS_TEST_VALUE    = 9'h100;
  localparam int          CRS_CNT_W         = 16;

  typedef enum logic [1:0] {
    CRS_ST_HOLD    = 2'b00,
    CRS_ST_EXTEND  = 2'b01,
    CRS_ST_RUN     = 2'b11
  } crs_state_e;

  typedef enum logic [2:0] {
    CRS_H_IDLE     = 3'b000,
    CRS_H_PROBE_WR = 3'b001,
    CRS_H_PROBE_RD = 3'b011,
    CRS_H_SWRST    = 3'b010,
    CRS_H_INIT     = 3'b110,
    CRS_H_READY    = 3'b111,
    CRS_H_WAIT     = 3'b101,
    CRS_H_CHECK    = 3'b100
  } crs_host_e;
endpackage : crs_pkg
